// ===== rtl/questionable_status_group.sv
// Questionable event latch, enable mask and status byte summary
`timescale 1ns/1ps
`default_nettype none
`include "ques_status_defines.svh"
module questionable_status_group
    import ques_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire cond_t cond_i,
    input wire host_cmd_t cmd_i,
    input wire logic std_event_summary_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic ques_summary_o,
    output logic [7:0] status_byte_o
);
    cond_t cond_sync_w;
    logic [15:0] event_reg;
    logic [15:0] event_next;
    logic [15:0] mask_reg;
    logic [15:0] mask_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic summary_reg;
    logic summary_next;
    logic [7:0] stb_reg;
    logic [7:0] stb_next;
    logic [15:0] set_vec;

    function automatic logic [15:0] cond_to_bits(input cond_t c);
        logic [15:0] v;
        v = 16'h0000;
        v[`QS_BIT_VOLT] = c.volt_unreg;
        v[`QS_BIT_CURR] = c.curr_unreg;
        v[`QS_BIT_TEMP] = c.fan_fault;
        v[`QS_BIT_OVP] = c.ovp_trip;
        v[`QS_BIT_OCP] = c.ocp_trip;
        return v & `QS_IMPL_MASK;
    endfunction : cond_to_bits

    cond_sync u_cond_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .cond_i(cond_i),
        .cond_o(cond_sync_w)
    );

    assign set_vec = cond_to_bits(cond_sync_w);

    // Event latch: a condition arriving with a clear still lands
    always_comb begin
        event_next = event_reg;
        if (cmd_i.read_event || cmd_i.clear_status) begin
            event_next = 16'h0000;
        end
        // Reset command and device clear deliberately not decoded here
        event_next = (event_next | set_vec) & `QS_IMPL_MASK;
    end

    // Enable mask: only a mask write changes it
    always_comb begin
        mask_next = mask_reg;
        if (cmd_i.write_mask) begin
            mask_next = cmd_i.wdata;
        end
    end

    // Read data: snapshot before the read-clear takes effect
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (cmd_i.read_event) begin
            rdata_next = event_reg;
            rvalid_next = 1'b1;
        end else if (cmd_i.read_mask) begin
            rdata_next = mask_reg;
            rvalid_next = 1'b1;
        end
    end

    // Summary and status byte follow the next-state values
    always_comb begin
        summary_next = |(event_next & mask_next);
        stb_next = `QS_STB_RESET;
        stb_next[`QS_STB_QUES_BIT] = summary_next;
        stb_next[`QS_STB_ESB_BIT] = std_event_summary_i;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            event_reg <= `QS_EVENT_RESET;
            mask_reg <= `QS_MASK_RESET;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            summary_reg <= 1'b0;
            stb_reg <= `QS_STB_RESET;
        end else begin
            event_reg <= event_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            summary_reg <= summary_next;
            stb_reg <= stb_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign ques_summary_o = summary_reg;
    assign status_byte_o = stb_reg;
endmodule : questionable_status_group
`default_nettype wire

// ===== inc/ques_status_defines.svh
// Constants for the questionable status group
`ifndef QUES_STATUS_DEFINES_SVH
`define QUES_STATUS_DEFINES_SVH
`define QS_WIDTH 16
`define QS_BIT_VOLT 0
`define QS_BIT_CURR 1
`define QS_BIT_TEMP 4
`define QS_BIT_OVP 9
`define QS_BIT_OCP 10
`define QS_IMPL_MASK 16'h0613
`define QS_EVENT_RESET 16'h0000
`define QS_MASK_RESET 16'h0000
`define QS_STB_QUES_BIT 3
`define QS_STB_ESB_BIT 5
`define QS_STB_RESET 8'h00
`define QS_SYNC_STAGES 2
`endif

// ===== inc/ques_status_pkg.sv
// Types for the questionable status group
package ques_status_pkg;
    typedef struct packed {
        logic volt_unreg;
        logic curr_unreg;
        logic fan_fault;
        logic ovp_trip;
        logic ocp_trip;
    } cond_t;

    typedef struct packed {
        logic read_event;
        logic read_mask;
        logic write_mask;
        logic clear_status;
        logic device_reset;
        logic device_clear;
        logic [15:0] wdata;
    } host_cmd_t;

    typedef enum logic [1:0] {
        RD_NONE,
        RD_EVENT,
        RD_MASK
    } rd_sel_t;
endpackage : ques_status_pkg

// ===== rtl/cond_sync.sv
// Two-stage synchroniser for the condition inputs
`timescale 1ns/1ps
`default_nettype none
module cond_sync
    import ques_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire cond_t cond_i,
    output cond_t cond_o
);
    cond_t stage1_reg;
    cond_t stage2_reg;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= cond_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign cond_o = stage2_reg;
endmodule : cond_sync
`default_nettype wire

// ===== verif/qs_props.sv
// Checker for the questionable status group
`timescale 1ns/1ps
`default_nettype none
module qs_props
    import ques_status_pkg::*;
(
    input wire logic clk_i, input wire logic reset_i, input wire cond_t cond_i,
    input wire host_cmd_t cmd_i, input wire logic std_event_summary_i,
    input wire logic [15:0] rdata_o, input wire logic rvalid_o,
    input wire logic ques_summary_o, input wire logic [7:0] status_byte_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_event_ack: assert property (
        cmd_i.read_event |=> rvalid_o) else $error("no ack");
    chk_mask_ack: assert property (
        cmd_i.read_mask |=> rvalid_o) else $error("no ack");
    chk_unused_zero: assert property (
        rvalid_o && $past(cmd_i.read_event) |-> !(rdata_o & 16'hf9ec))
        else $error("unused bit set");
    chk_sum_bit: assert property (
        status_byte_o[3] == ques_summary_o) else $error("bit 3");
    chk_esb_pass: assert property (
        !$past(reset_i) |-> status_byte_o[5] == $past(std_event_summary_i))
        else $error("bit 5");
    chk_event_hold: assert property (
        ques_summary_o && !cmd_i.clear_status && !cmd_i.read_event
        && !cmd_i.write_mask |=> ques_summary_o) else $error("lost");
    chk_cls_clear: assert property (
        cmd_i.clear_status && cond_i == '0 && $past(cond_i) == '0
        && $past(cond_i, 2) == '0 |=> !ques_summary_o) else $error("cls");
    chk_mask_zero: assert property (
        cmd_i.write_mask && cmd_i.wdata == 16'h0000 |=> !ques_summary_o)
        else $error("mask 0");
endmodule : qs_props
bind questionable_status_group qs_props u_props (.clk_i(clk_i),
    .reset_i(reset_i), .cond_i(cond_i), .cmd_i(cmd_i), .rdata_o(rdata_o),
    .std_event_summary_i(std_event_summary_i), .rvalid_o(rvalid_o),
    .ques_summary_o(ques_summary_o), .status_byte_o(status_byte_o));
`default_nettype wire

// ===== verif/host_model.sv
// Remote host issuing status commands
`timescale 1ns/1ps
`default_nettype none
module host_model
    import ques_status_pkg::*;
(
    input wire logic clk_i,
    output host_cmd_t cmd_o
);
    initial cmd_o = '0;
    // One-cycle strobe; the command is driven at a negedge and cleared at the next
    task automatic send(input host_cmd_t c);
        @(negedge clk_i) cmd_o = c;
        @(negedge clk_i) cmd_o = '0;
    endtask : send
endmodule : host_model
`default_nettype wire

// ===== verif/tb_top.sv
// Testbench for the questionable status group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ques_status_pkg::*;
    logic clk_i = 0, reset_i = 1, std = 0, rv, qs;
    cond_t cnd = '0;
    host_cmd_t cmd;
    logic [15:0] rd;
    logic [7:0] sb;
    logic [15:0] wt [5] = '{16'h0400, 16'h0200, 16'h0010, 16'h0002, 16'h0001};
    int n_fail = 0, cmp_count = 0, cyc = 0;
    always #20 clk_i = ~clk_i;
    questionable_status_group dut (.clk_i(clk_i), .reset_i(reset_i),
        .cond_i(cnd), .cmd_i(cmd), .std_event_summary_i(std), .rdata_o(rd),
        .rvalid_o(rv), .ques_summary_o(qs), .status_byte_o(sb));
    host_model host (.clk_i(clk_i), .cmd_o(cmd));
    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        reset_i = 0;
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_i) cnd = cond_t'(5'h01 << i);
            @(negedge clk_i) cnd = '0;
            repeat (4) @(negedge clk_i);
            host.send({6'h20, 16'h0000});
            chk(rd, wt[i]);
            chk({15'h0000, rv}, 16'h0001);
            host.send({6'h20, 16'h0000});
            chk(rd, 16'h0000);
        end
        @(negedge clk_i) cnd = cond_t'(5'h1f);
        @(negedge clk_i) cnd = '0;
        repeat (4) @(negedge clk_i);
        host.send({6'h20, 16'h0000});
        chk(rd, 16'h0613);
        host.send({6'h08, 16'h0010});
        @(negedge clk_i) cnd = cond_t'(5'h04);
        std = 1;
        @(negedge clk_i) cnd = '0;
        repeat (4) @(negedge clk_i);
        host.send({6'h03, 16'h0000});
        chk({8'h00, sb}, 16'h0028);
        chk({15'h0000, qs}, 16'h0001);
        host.send({6'h04, 16'h0000});
        chk({8'h00, sb}, 16'h0020);
        chk({15'h0000, qs}, 16'h0000);
        host.send({6'h20, 16'h0000});
        chk(rd, 16'h0000);
        host.send({6'h10, 16'h0000});
        chk(rd, 16'h0010);
        host.send({6'h10, 16'h0000});
        chk(rd, 16'h0010);
        host.send({6'h08, 16'h0000});
        host.send({6'h10, 16'h0000});
        chk(rd, 16'h0000);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
